// ==== rtl/ebt_ext_bus_attr_termination.sv ====
// External bus attribute encoder and termination resolver, software-driven over AHB-Lite.
// Assumes slave termination pins are asynchronous to clk and pulled high when undriven.
// Operation
// - Drive four access-type bits plus trace and reservation flags per transfer.
// - Attribute outputs are valid in the cycle the special start strobe asserts.
// - Special start strobe low marks special transfer, high otherwise.
// - Transfer start strobe low for the first cycle, high otherwise.
// - Top access-type bit zero on every transfer (idle drives type F); reserved encodings never generated.
// - Second access-type bit: 0 supervisor, 1 user.
// - Third access-type bit: 0 instruction, 1 data.
// - Traced fetch drives lowest bit 0, trace 0, reservation 1.
// - Reservation data drives lowest bit 0, reservation 0, trace 1.
// - Special strobe without start strobe signals a show cycle, same encoding.
// - Both strobes together mean a normal transfer with show attribute.
// - Assert burst continuation while another data beat follows.
// - Master may end a burst early by negating burst continuation.
// - On burst inhibit, finish as single transfers with incrementing address.
// - On error acknowledge the master aborts the current cycle.
// - Error acknowledge beats every other termination signal.
// - Priority: error, then acknowledge, then retry alone.
`timescale 1ns/1ps

module ebt_ext_bus_attr_termination
  import ebt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ebt_term_in_t termPinsN,
  output ebt_attr_t attrPins,
  output logic burstContinuationN,
  output logic [1:0] wordOffset
);

  // AHB slave state
  logic [31:0] addrReg, addrNext;
  logic wrPendReg, wrPendNext;
  logic rdPendReg, rdPendNext;
  logic [31:0] rdataReg, rdataNext;
  // Control fields written by software
  logic userModeReg, userModeNext;
  logic dataAccReg, dataAccNext;
  logic traceReg, traceNext;
  logic reserveReg, reserveNext;
  logic showReg, showNext;
  logic showOnlyReg, showOnlyNext;
  logic burstReg, burstNext;
  logic [3:0] beatsReg, beatsNext;
  logic goReg, goNext;
  logic stopReg, stopNext;
  // Status
  ebt_term_t termReg, termNext;
  logic busyReg, busyNext;
  logic inhibitSeenReg, inhibitSeenNext;
  logic [3:0] doneCntReg, doneCntNext;
  // Bus cycle
  ebt_state_t stateReg, stateNext;
  ebt_attr_t attrReg, attrNext;
  logic burstContNReg, burstContNNext;
  logic [1:0] offsetReg, offsetNext;
  logic [3:0] leftReg, leftNext;
  logic singleModeReg, singleModeNext;
  // Synchronisers for the termination pins
  ebt_term_in_t syncAReg, syncBReg;
  // Bus response in flops; this slave never stalls and never errors
  logic hreadyoutReg, hrespReg;

  logic ackIn, errIn, inhIn, retryIn;
  ebt_term_t resolved;
  logic [3:0] beatReq;

  // Two flip-flops; pins come from the slaves' side
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncAReg <= '1;
      syncBReg <= '1;
    end else begin
      syncAReg <= termPinsN;
      syncBReg <= syncAReg;
    end
  end

  // A high level, including a pulled-up idle line, counts as negated
  assign ackIn = (syncBReg.transferAckN == EBT_PIN_ASSERTED);
  assign errIn = (syncBReg.transferErrorAckN == EBT_PIN_ASSERTED);
  assign inhIn = (syncBReg.noBurstSupportN == EBT_PIN_ASSERTED);
  assign retryIn = (syncBReg.retryN == EBT_PIN_ASSERTED);

  // Error wins over acknowledge, acknowledge over retry
  always_comb begin
    if (errIn) begin
      resolved = EBT_TERM_ERROR;
    end else if (ackIn) begin
      resolved = EBT_TERM_NORMAL;
    end else if (retryIn) begin
      resolved = EBT_TERM_RETRY;
    end else begin
      resolved = EBT_TERM_NONE;
    end
  end

  // Zero beats are treated as one; more than four is clipped to the burst maximum
  assign beatReq = (hwdata[11:8] == EBT_BEAT_RESET) ? 4'h1 :
                   (hwdata[11:8] > EBT_MAX_BEATS) ? EBT_MAX_BEATS : hwdata[11:8];

  // Register file and AHB-Lite slave; zero wait states
  always_comb begin
    addrNext = addrReg;
    wrPendNext = 1'b0;
    rdPendNext = 1'b0;
    rdataNext = rdataReg;
    userModeNext = userModeReg;
    dataAccNext = dataAccReg;
    traceNext = traceReg;
    reserveNext = reserveReg;
    showNext = showReg;
    showOnlyNext = showOnlyReg;
    burstNext = burstReg;
    beatsNext = beatsReg;
    goNext = 1'b0;
    stopNext = stopReg;
    if (hsel && hready && htrans[1]) begin
      addrNext = haddr;
      wrPendNext = hwrite;
      rdPendNext = !hwrite;
    end
    if (wrPendReg) begin
      case (addrReg)
        EBT_REG_CTRL: begin
          userModeNext = hwdata[0];
          dataAccNext = hwdata[1];
          traceNext = hwdata[2];
          reserveNext = hwdata[3];
          showNext = hwdata[4];
          showOnlyNext = hwdata[5];
        end
        EBT_REG_REQ: begin
          // Ignored while a cycle runs, except the early stop bit
          if (!busyReg) begin
            burstNext = hwdata[1];
            beatsNext = beatReq;
            goNext = hwdata[0];
            stopNext = 1'b0;
          end else begin
            stopNext = hwdata[2];
          end
        end
        default: begin
        end
      endcase
    end
    // Look up in the address phase so the data stands through the data phase
    if (rdPendNext) begin
      case (haddr)
        EBT_REG_CTRL: rdataNext = {26'h000_0000, showOnlyReg, showReg, reserveReg, traceReg, dataAccReg, userModeReg};
        EBT_REG_REQ: rdataNext = {20'h0_0000, beatsReg, 5'h00, stopReg, burstReg, busyReg};
        EBT_REG_STATUS: rdataNext = {22'h00_0000, doneCntReg, inhibitSeenReg, busyReg, offsetReg, termReg};
        default: rdataNext = 32'h0000_0000;
      endcase
    end
  end

  // Bus cycle sequencer
  always_comb begin
    stateNext = stateReg;
    attrNext = attrReg;
    burstContNNext = burstContNReg;
    offsetNext = offsetReg;
    leftNext = leftReg;
    singleModeNext = singleModeReg;
    termNext = termReg;
    busyNext = busyReg;
    inhibitSeenNext = inhibitSeenReg;
    doneCntNext = doneCntReg;
    case (stateReg)
      EBT_IDLE: begin
        // Idle pins: strobes high, flags high
        attrNext = {EBT_PIN_NEGATED, EBT_PIN_NEGATED, EBT_TYPE_IDLE, EBT_PIN_NEGATED, EBT_PIN_NEGATED};
        burstContNNext = EBT_PIN_NEGATED;
        if (goReg) begin
          // Attributes are rebuilt in START from the latched control word
          stateNext = EBT_START;
          busyNext = 1'b1;
          offsetNext = 2'h0;
          leftNext = beatsReg;
          singleModeNext = 1'b0;
          inhibitSeenNext = 1'b0;
          doneCntNext = 4'h0;
          termNext = EBT_TERM_NONE;
        end
      end
      EBT_START: begin
        // Attributes stand with the special strobe edge
        attrNext.accessTypeBits[3] = EBT_ADDR_RESERVED_BIT;
        attrNext.accessTypeBits[2] = userModeReg;
        attrNext.accessTypeBits[1] = dataAccReg;
        // Trace only on fetches, reservation only on data
        attrNext.accessTypeBits[0] = dataAccReg ? !reserveReg : !traceReg;
        attrNext.traceFlag = dataAccReg ? EBT_PIN_NEGATED : !traceReg;
        attrNext.reservationFlag = dataAccReg ? !reserveReg : EBT_PIN_NEGATED;
        // Show-only cycles keep start strobe high
        attrNext.specialStartStrobeN = !showReg;
        attrNext.transferStartStrobeN = showReg && showOnlyReg;
        // Warn of a following beat only in true burst mode
        burstContNNext = !(burstReg && !singleModeReg && (leftReg > 4'h1));
        stateNext = EBT_DATA;
      end
      EBT_DATA: begin
        // Strobes are one cycle wide; attributes hold until terminated
        attrNext.transferStartStrobeN = EBT_PIN_NEGATED;
        attrNext.specialStartStrobeN = EBT_PIN_NEGATED;
        if (stopReg && burstReg) begin
          // Early end: negate continuation, slave stops after this beat
          burstContNNext = EBT_PIN_NEGATED;
        end
        if (resolved == EBT_TERM_ERROR) begin
          // Abort without further beats
          termNext = EBT_TERM_ERROR;
          stateNext = EBT_DONE;
        end else if (resolved == EBT_TERM_NORMAL) begin
          // One acknowledge per beat
          doneCntNext = doneCntReg + 4'h1;
          leftNext = leftReg - 4'h1;
          offsetNext = offsetReg + EBT_WORD_STEP;
          termNext = EBT_TERM_NORMAL;
          if (inhIn && burstReg && !singleModeReg) begin
            // Burst refused: rest go as single cycles
            singleModeNext = 1'b1;
            inhibitSeenNext = 1'b1;
          end
          if ((leftReg == 4'h1) || (stopReg && burstReg) || (!burstReg)) begin
            stateNext = EBT_DONE;
          end else if (singleModeReg || (inhIn && burstReg)) begin
            // New address phase at the next word
            stateNext = EBT_START;
          end else begin
            burstContNNext = !(leftReg > 4'h2);
          end
        end else if (resolved == EBT_TERM_RETRY) begin
          // Retry after the first beat or in single mode counts as error
          termNext = ((doneCntReg != 4'h0) || singleModeReg) ? EBT_TERM_ERROR : EBT_TERM_RETRY;
          stateNext = EBT_DONE;
        end
      end
      EBT_DONE: begin
        // One all-high cycle between cycles keeps a late slave off a stale strobe
        attrNext = {EBT_PIN_NEGATED, EBT_PIN_NEGATED, EBT_TYPE_IDLE, EBT_PIN_NEGATED, EBT_PIN_NEGATED};
        burstContNNext = EBT_PIN_NEGATED;
        busyNext = 1'b0;
        stateNext = EBT_IDLE;
      end
      default: begin
        stateNext = EBT_IDLE;
      end
    endcase
  end

  // Reset leaves every pin at its negated level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addrReg <= 32'h0000_0000;
      wrPendReg <= 1'b0;
      rdPendReg <= 1'b0;
      rdataReg <= 32'h0000_0000;
      userModeReg <= 1'b0;
      dataAccReg <= 1'b0;
      traceReg <= 1'b0;
      reserveReg <= 1'b0;
      showReg <= 1'b0;
      showOnlyReg <= 1'b0;
      burstReg <= 1'b0;
      beatsReg <= 4'h1;
      goReg <= 1'b0;
      stopReg <= 1'b0;
      termReg <= EBT_TERM_NONE;
      busyReg <= 1'b0;
      inhibitSeenReg <= 1'b0;
      doneCntReg <= 4'h0;
      stateReg <= EBT_IDLE;
      attrReg <= '1;
      burstContNReg <= 1'b1;
      hreadyoutReg <= 1'b1;
      hrespReg <= 1'b0;
      offsetReg <= 2'h0;
      leftReg <= 4'h0;
      singleModeReg <= 1'b0;
    end else begin
      addrReg <= addrNext;
      wrPendReg <= wrPendNext;
      rdPendReg <= rdPendNext;
      rdataReg <= rdataNext;
      userModeReg <= userModeNext;
      dataAccReg <= dataAccNext;
      traceReg <= traceNext;
      reserveReg <= reserveNext;
      showReg <= showNext;
      showOnlyReg <= showOnlyNext;
      burstReg <= burstNext;
      beatsReg <= beatsNext;
      goReg <= goNext;
      stopReg <= stopNext;
      termReg <= termNext;
      busyReg <= busyNext;
      inhibitSeenReg <= inhibitSeenNext;
      doneCntReg <= doneCntNext;
      stateReg <= stateNext;
      attrReg <= attrNext;
      burstContNReg <= burstContNNext;
      hreadyoutReg <= 1'b1;
      hrespReg <= 1'b0;
      offsetReg <= offsetNext;
      leftReg <= leftNext;
      singleModeReg <= singleModeNext;
    end
  end

  // All outputs straight from flip-flops; the bus never waits and never errors
  assign hrdata = rdataReg;
  assign hreadyout = hreadyoutReg;
  assign hresp = hrespReg;
  assign attrPins = attrReg;
  assign burstContinuationN = burstContNReg;
  assign wordOffset = offsetReg;

endmodule

// ==== rtl/ebt_pkg.sv ====
// Package for the external bus attribute and termination block.
// Assumes a single bus clock; all pin levels are active low where noted.
package ebt_pkg;

  localparam int EBT_TYPE_WIDTH = 4;
  localparam logic [3:0] EBT_MAX_BEATS = 4'h4;
  localparam logic [3:0] EBT_BEAT_RESET = 4'h0;
  localparam logic [3:0] EBT_TYPE_IDLE = 4'hF;
  localparam logic EBT_PIN_NEGATED = 1'b1;
  localparam logic EBT_PIN_ASSERTED = 1'b0;
  localparam logic EBT_ADDR_RESERVED_BIT = 1'b0;
  localparam logic [31:0] EBT_REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] EBT_REG_REQ = 32'h0000_0004;
  localparam logic [31:0] EBT_REG_STATUS = 32'h0000_0008;
  localparam logic [1:0] EBT_WORD_STEP = 2'h1;

  // Bus cycle states, Gray coded along start -> data -> done
  typedef enum logic [1:0] {
    EBT_IDLE = 2'b00,
    EBT_START = 2'b01,
    EBT_DATA = 2'b11,
    EBT_DONE = 2'b10
  } ebt_state_t;

  typedef enum logic [1:0] {
    EBT_TERM_NONE = 2'b00,
    EBT_TERM_NORMAL = 2'b01,
    EBT_TERM_ERROR = 2'b10,
    EBT_TERM_RETRY = 2'b11
  } ebt_term_t;

  // Attribute pin group as driven onto the bus
  typedef struct packed {
    logic specialStartStrobeN;
    logic transferStartStrobeN;
    logic [3:0] accessTypeBits;
    logic traceFlag;
    logic reservationFlag;
  } ebt_attr_t;

  // Termination inputs from the slaves, active low
  typedef struct packed {
    logic transferAckN;
    logic noBurstSupportN;
    logic transferErrorAckN;
    logic retryN;
  } ebt_term_in_t;

endpackage

// ==== verif/ebt_checker_sva.sv ====
// Checker for the attribute and termination block.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps

module ebt_checker_sva
  import ebt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire ebt_term_in_t termPinsN,
  input wire ebt_attr_t attrPins,
  input wire logic burstContinuationN,
  input wire logic [1:0] wordOffset
);
  logic [2:0] ackAge_reg;
  logic [2:0] ackAge_next;
  logic strobe;

  assign strobe = !attrPins.specialStartStrobeN || !attrPins.transferStartStrobeN;

  // Saturating age, so a stale acknowledge cannot excuse an offset step
  always_comb begin
    ackAge_next = ackAge_reg;
    if (!termPinsN.transferAckN) begin
      ackAge_next = 3'h0;
    end else if (ackAge_reg != 3'h7) begin
      ackAge_next = ackAge_reg + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ackAge_reg <= 3'h7;
    end else begin
      ackAge_reg <= ackAge_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_top_bit_zero: assert property (
    strobe |-> !attrPins.accessTypeBits[3]) else $error("Top access-type bit set");
  a_start_pulse: assert property (
    !attrPins.transferStartStrobeN |=> attrPins.transferStartStrobeN) else $error("Start strobe too long");
  a_special_pulse: assert property (
    !attrPins.specialStartStrobeN |=> attrPins.specialStartStrobeN) else $error("Special strobe too long");
  a_low_bit_flags: assert property (
    strobe |-> attrPins.accessTypeBits[0] == (attrPins.traceFlag && attrPins.reservationFlag))
    else $error("Lowest type bit disagrees with flags");
  a_attr_hold: assert property (
    strobe |=> $stable({attrPins.accessTypeBits, attrPins.traceFlag, attrPins.reservationFlag}))
    else $error("Attributes moved after strobe");
  a_offset_needs_ack: assert property (
    (wordOffset != $past(wordOffset) && wordOffset != 2'h0) |-> ackAge_reg <= 3'h5)
    else $error("Offset stepped without acknowledge");
  a_cont_last_beat: assert property (
    !burstContinuationN |-> wordOffset != 2'h3) else $error("Continuation on last beat");
  a_error_no_step: assert property (
    !termPinsN.transferErrorAckN |-> ##1 (2'(wordOffset - $past(wordOffset)) != 2'h1) [*4])
    else $error("Beat counted despite error");
endmodule

bind ebt_ext_bus_attr_termination ebt_checker_sva u_ebt_checker_sva (
  .clk(clk),
  .reset(reset),
  .termPinsN(termPinsN),
  .attrPins(attrPins),
  .burstContinuationN(burstContinuationN),
  .wordOffset(wordOffset)
);

// ==== verif/ebt_ext_bus_attr_termination_test.sv ====
// Self-checking bench for the attribute and termination block.
// Drives AHB-Lite as sole master; slave model answers the bus.
`timescale 1ns/1ps

module ebt_ext_bus_attr_termination_test;
  import ebt_pkg::*;
  logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, inhibit, burstContN;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, faultKind, wordOffset;
  logic [2:0] hsize;
  logic [3:0] waitCycles;
  ebt_term_in_t termPinsN;
  ebt_attr_t attrPins, seenAttr;
  int bad_count, n_checks, strobes;

  assign hready = hreadyout;
  always #5 clk = ~clk;

  ebt_ext_bus_attr_termination u_ebt_ext_bus_attr_termination (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .termPinsN(termPinsN), .attrPins(attrPins),
    .burstContinuationN(burstContN), .wordOffset(wordOffset));
  ebt_slave_model u_ebt_slave_model (.clk(clk), .attrPins(attrPins), .burstContinuationN(burstContN),
    .waitCycles(waitCycles), .faultKind(faultKind), .inhibit(inhibit), .termPinsN(termPinsN));

  always @(posedge clk) begin
    if (!attrPins.specialStartStrobeN || !attrPins.transferStartStrobeN) begin
      strobes <= strobes + 1;
      seenAttr <= attrPins;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  task conclude;
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00; hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0000_0000);
    if (n >= 100) begin bad_count++; conclude(); end
  endtask

  // Bit order: special, start, type[3:0], trace, reservation
  function automatic logic [7:0] expAttr(input logic [5:0] c);
    logic f;
    f = c[1] ? c[3] : c[2];
    return {!c[4], c[4] && c[5], 1'b0, c[0], c[1], !f, !(f && !c[1]), !(f && c[1])};
  endfunction

  function automatic logic [31:0] st(input logic [1:0] term, input logic [3:0] beats, input logic inh);
    return {22'h0, beats, inh, 1'b0, beats[1:0], term};
  endfunction

  // Legal control word: show-only needs show, trace only on fetches
  function automatic logic [5:0] rc();
    logic [5:0] c;
    c = 6'($urandom);
    return {c[5] & c[4], c[4], c[3] & c[1], c[2] & ~c[1], c[1:0]};
  endfunction

  // Request bit2 set means stop is written while the burst runs
  task run(input logic [5:0] c, input logic [11:0] req, input logic [1:0] fk, input logic inh,
    input logic [31:0] expSt, input int expStr);
    int n, s0;
    waitCycles <= 4'($urandom_range(0, 6)); faultKind <= fk; inhibit <= inh;
    ahb(EBT_REG_CTRL, 1'b1, {26'h0, c});
    s0 = strobes;
    ahb(EBT_REG_REQ, 1'b1, {20'h0, req & 12'hFFB});
    if (req[2]) ahb(EBT_REG_REQ, 1'b1, {20'h0, req});
    repeat (3) @(posedge clk);
    n = 0;
    do begin ahb(EBT_REG_STATUS, 1'b0, 32'h0); n++; end while (rd[4] !== 1'b0 && n < 100);
    if (n >= 100) begin bad_count++; conclude(); end
    check(rd & 32'h0000_03FF, expSt);
    check({30'h0, wordOffset}, {30'h0, expSt[3:2]});
    check(strobes - s0, expStr);
    check({24'h0, seenAttr}, {24'h0, expAttr(c)});
  endtask

  initial begin
    int i;
    clk = 0; reset = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010; hwdata = 0;
    waitCycles = 0; faultKind = 0; inhibit = 0; bad_count = 0; n_checks = 0; strobes = 0;
    void'($urandom(57425));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    check({23'h0, burstContN, attrPins}, 32'h0000_01FF);
    ahb(EBT_REG_STATUS, 1'b0, 32'h0);
    check(rd, 32'h0000_0000);
    ahb(32'h0000_0010, 1'b1, 32'hFFFF_FFFF);
    ahb(32'h0000_0010, 1'b0, 32'h0);
    check(rd, 32'h0000_0000);
    // Every privilege, space and flag in each strobe mode
    for (i = 0; i < 24; i++) begin
      run({i >= 16, i >= 8, i[2] & i[1], i[2] & ~i[1], i[1], i[0]}, 12'h101, 2'h0, 1'b0, st(2'h1, 4'h1, 1'b0), 1);
    end
    run(rc(), 12'hF03, 2'h0, 1'b0, st(2'h1, 4'h4, 1'b0), 1);
    run(rc(), 12'h003, 2'h0, 1'b0, st(2'h1, 4'h1, 1'b0), 1);
    run(rc(), 12'h407, 2'h0, 1'b0, st(2'h1, 4'h1, 1'b0), 1);
    run(rc(), 12'h303, 2'h0, 1'b1, st(2'h1, 4'h3, 1'b1), 3);
    run(rc(), 12'h403, 2'h1, 1'b0, st(2'h2, 4'h0, 1'b0), 1);
    run(rc(), 12'h403, 2'h2, 1'b0, st(2'h2, 4'h0, 1'b0), 1);
    run(rc(), 12'h403, 2'h3, 1'b0, st(2'h3, 4'h0, 1'b0), 1);
    run(rc(), 12'h101, 2'h3, 1'b0, st(2'h3, 4'h0, 1'b0), 1);
    conclude();
  end
endmodule

// ==== verif/ebt_slave_model.sv ====
// Behavioural external slave answering the block's bus cycles.
// Termination lines are pulled up, so released lines read high.
`timescale 1ns/1ps

module ebt_slave_model
  import ebt_pkg::*;
(
  input wire logic clk,
  input wire ebt_attr_t attrPins,
  input wire logic burstContinuationN,
  input wire logic [3:0] waitCycles,
  input wire logic [1:0] faultKind,
  input wire logic inhibit,
  output ebt_term_in_t termPinsN
);
  // Continuation is read at the acknowledge edge, before the design updates it
  logic more;

  initial begin
    termPinsN = '1;
    forever begin
      @(posedge clk);
      if (!attrPins.transferStartStrobeN || !attrPins.specialStartStrobeN) begin
        more = 1'b1;
        while (more) begin
          repeat (waitCycles + 1) @(posedge clk);
          termPinsN.transferAckN <= faultKind[0];
          termPinsN.transferErrorAckN <= faultKind[0] ~^ faultKind[1];
          termPinsN.retryN <= faultKind != 2'h3;
          termPinsN.noBurstSupportN <= !inhibit;
          more = !burstContinuationN && !inhibit && faultKind == 2'h0;
          @(posedge clk);
          // Burst inhibit stays tied low while the system runs without bursts
          termPinsN <= {1'b1, !inhibit, 1'b1, 1'b1};
          repeat (3) @(posedge clk);
        end
      end
    end
  end
endmodule
